// ===== core/clock_cfg_pkg.sv
// Package for the generic clock configuration register page
package clock_cfg_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_PIN_CONFIG = 8'h18; // Pin 15 direction and selector
	localparam logic [7:0] OFS_SPARE = 8'h19; // Rail hold and holdover mapping
	localparam logic [7:0] OFS_FUSE_PTR = 8'h22; // One-hot fuse page pointer
	localparam logic [7:0] OFS_IO_SUPPLY = 8'h23; // IO supply and free-run enable
	localparam logic [7:0] OFS_IN_FIX_EN = 8'h24; // Inputs and fixed outputs
	localparam logic [7:0] OFS_FLEX_EN = 8'h25; // Flexible outputs
	localparam logic [7:0] OFS_WAKE_SEL = 8'h26; // Wake-up free-run PLL
	localparam logic [7:0] OFS_STATUS = 8'h1F; // Read-only page status

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_REG = 8'h00; // Every field clears

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int POS_PIN_DIR = 3; // Pin 15 direction bit
	localparam int POS_SEL_HI = 2; // Selector top bit
	localparam int POS_RAIL_HOLD = 7; // Hold rail on the left
	localparam int POS_HO_MAP = 6; // Per-PLL holdover mapping
	localparam int POS_RESV_PAGE = 4; // Reserved fuse page bit
	localparam int POS_SUPPLY = 7; // IO supply from input supply
	localparam int POS_FREE_EN = 5; // Free-run-at-wake enable
	localparam int POS_WAKE_HI = 7; // Wake PLL select top bit
	localparam int POS_WAKE_LO = 6; // Wake PLL select low bit

	// ----------------------------------------------------------------
	// Selector codes for pin 15
	// ----------------------------------------------------------------
	localparam logic [2:0] SEL_ZERO = 3'h0; // Constant low
	localparam logic [2:0] SEL_ALL = 3'h1; // Every alarm
	localparam logic [2:0] SEL_PLL = 3'h2; // PLL alarms only
	localparam logic [2:0] SEL_MON = 3'h3; // Input monitor alarms only
	localparam logic [2:0] SEL_STATUS = 3'h4; // Live monitoring status
	localparam logic [2:0] SEL_DBG0 = 3'h5; // Internal debug 0
	localparam logic [2:0] SEL_DBG1 = 3'h6; // Internal debug 1
	localparam logic [2:0] SEL_DBG2 = 3'h7; // Internal debug 2

	// ----------------------------------------------------------------
	// Monitor events carried from the detectors
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] clock_loss; // Loss of clock per input
		logic [3:0] drift; // Coarse frequency drift per input
		logic [3:0] loss_of_lock; // Loss of lock per PLL
		logic [3:0] freeze; // Holdover freeze per PLL
		logic monitor; // Live clock monitoring status
		logic [2:0] debug; // Internal debug taps
	} sense_t;

	// ----------------------------------------------------------------
	// Alarm reductions
	// ----------------------------------------------------------------
	function automatic logic pll_alarm(input sense_t s);
		pll_alarm = |{s.loss_of_lock, s.freeze};
	endfunction : pll_alarm

	function automatic logic mon_alarm(input sense_t s);
		mon_alarm = |{s.clock_loss, s.drift};
	endfunction : mon_alarm

	// Zero or a single bit, and never the reserved page
	function automatic logic fuse_legal(input logic [7:0] v);
		fuse_legal = ((v & (v - 8'h01)) == 8'h00) && !v[POS_RESV_PAGE];
	endfunction : fuse_legal

endpackage : clock_cfg_pkg

// ===== core/clock_generic_config_regs.sv
// Generic configuration register page of a multi-PLL clock generator
//
// Contract
// - Selector zero drives constant low on pin
// - Selector drives pin only in output mode
// - Code one drives OR of all alarms
// - Code two drives OR of PLL alarms
// - Code three drives OR of input alarms
// - Code four monitor status; rest debug only
// - Spare bit seven holds pad rail left
// - Spare bit six maps per-PLL forced holdover
// - One-hot fuse pointer; page four refused
// - Supply bit picks input or core rail
// - Four active-low clock input enables
// - Two active-low bottom fixed output enables
// - Two active-low top fixed output enables
// - Eight active-low flexible output enables
// - Wake free-run PLL; valid flag gated by enable
// - Direction bit: zero input, one output
`timescale 1ns/100ps
module clock_generic_config_regs
	import clock_cfg_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Register port
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_ack,
	// Detector events, asynchronous
	input wire sense_t monitor_events,
	// Per-PLL holdover requests from the control register elsewhere
	input wire logic [3:0] holdover_force_req,
	// Pin 15 as three signals
	input wire logic multipurpose_pin_15_in,
	output logic multipurpose_pin_15_out,
	output logic multipurpose_pin_15_oe,
	// Supply controls
	output logic rail_switch_allowed,
	output logic io_supply_from_input,
	// Holdover forcing per PLL
	output logic [3:0] pll_force_holdover,
	// Fuse page pointer
	output logic [7:0] fuse_page_select,
	// Active-low enables
	output logic [3:0] clock_input_enable_n,
	output logic [1:0] bottom_output_enable_n,
	output logic [1:0] top_output_enable_n,
	output logic [7:0] flex_output_enable_n,
	// Wake-up free run
	output logic free_run_valid,
	output logic [1:0] free_run_pll
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	// Whole module state, registered as one word
	typedef struct packed {
		logic [7:0] pin_config; // Direction and selector
		logic [7:0] spare; // Rail hold and holdover map
		logic [7:0] fuse_ptr; // One-hot page pointer
		logic [7:0] io_supply; // Supply and free-run enable
		logic [7:0] in_fix_en; // Input and fixed output enables
		logic [7:0] flex_en; // Flex output enables
		logic [7:0] wake_sel; // Wake PLL select
		sense_t ev_meta; // First synchroniser stage
		sense_t ev_sync; // Second synchroniser stage
		logic pin_meta; // Pin input first stage
		logic pin_sync; // Pin input second stage
		logic pin_out; // Driven pin level
		logic pin_oe; // Pin drive enable
		logic [3:0] force_ho; // Holdover forcing
		logic free_valid; // Free-run selection active
		logic fuse_err; // Refused fuse write seen
		logic [7:0] rdata; // Read answer
		logic ack; // Access answered
	} state_t;

	state_t state; // Current state
	state_t next_state; // Next state
	logic selected; // Signal chosen by the selector

	// ----------------------------------------------------------------
	// Signal selector
	// ----------------------------------------------------------------
	// Works on synchronised events only
	pin_signal_mux u_mux (
		.events(state.ev_sync),
		.select(state.pin_config[POS_SEL_HI:0]),
		.selected(selected)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Register writes, reads, synchronisers and output flops
	always_comb begin
		next_state = state;

		// Two-flop synchronisers for asynchronous inputs
		next_state.ev_meta = monitor_events;
		next_state.ev_sync = state.ev_meta;
		next_state.pin_meta = multipurpose_pin_15_in;
		next_state.pin_sync = state.pin_meta;

		// Pin driven only in output mode
		if (state.pin_config[POS_PIN_DIR]) begin
			next_state.pin_oe = 1'b1;
			next_state.pin_out = selected;
		end else begin
			// Input mode keeps the selection off the pin
			next_state.pin_oe = 1'b0;
			next_state.pin_out = 1'b0;
		end

		// Holdover requests pass only when mapped
		if (state.spare[POS_HO_MAP]) begin
			next_state.force_ho = holdover_force_req;
		end else begin
			next_state.force_ho = 4'h0;
		end

		// Free-run choice acts only when enabled
		next_state.free_valid = state.io_supply[POS_FREE_EN];

		// Answer strobe lasts one cycle
		next_state.ack = 1'b0;

		// Register writes
		if (reg_write) begin
			next_state.ack = 1'b1;
			unique case (reg_addr)
				OFS_PIN_CONFIG: next_state.pin_config = reg_wdata;
				OFS_SPARE: next_state.spare = reg_wdata;
				OFS_FUSE_PTR: begin
					// Only zero or a single legal page is taken
					if (fuse_legal(reg_wdata)) begin
						next_state.fuse_ptr = reg_wdata;
						next_state.fuse_err = 1'b0;
					end else begin
						next_state.fuse_err = 1'b1;
					end
				end
				OFS_IO_SUPPLY: next_state.io_supply = reg_wdata;
				OFS_IN_FIX_EN: next_state.in_fix_en = reg_wdata;
				OFS_FLEX_EN: next_state.flex_en = reg_wdata;
				OFS_WAKE_SEL: next_state.wake_sel = reg_wdata;
				default: begin
					// Unmapped or read-only: ignored
				end
			endcase
		end else if (reg_read) begin
			// Register reads; unmapped answers zero
			next_state.ack = 1'b1;
			unique case (reg_addr)
				OFS_PIN_CONFIG: next_state.rdata = state.pin_config;
				OFS_SPARE: next_state.rdata = state.spare;
				OFS_FUSE_PTR: next_state.rdata = state.fuse_ptr;
				OFS_IO_SUPPLY: next_state.rdata = state.io_supply;
				OFS_IN_FIX_EN: next_state.rdata = state.in_fix_en;
				OFS_FLEX_EN: next_state.rdata = state.flex_en;
				OFS_WAKE_SEL: next_state.rdata = state.wake_sel;
				OFS_STATUS: begin
					// Pin level, selected signal, refused fuse write
					next_state.rdata = {5'h00, state.fuse_err, state.pin_out,
						state.pin_sync};
				end
				default: next_state.rdata = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Every field clears on reset
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Register port answer
	assign reg_rdata = state.rdata;
	assign reg_ack = state.ack;

	// Pin 15 drive
	assign multipurpose_pin_15_out = state.pin_out;
	assign multipurpose_pin_15_oe = state.pin_oe;

	// Rail switch allowed while the hold bit is clear
	assign rail_switch_allowed = ~state.spare[POS_RAIL_HOLD];

	// One means input supply, zero core supply
	assign io_supply_from_input = state.io_supply[POS_SUPPLY];

	// Holdover forcing
	assign pll_force_holdover = state.force_ho;

	// Fuse pointer as stored
	assign fuse_page_select = state.fuse_ptr;

	// Active-low enables straight from the register bits
	assign clock_input_enable_n = state.in_fix_en[7:4];
	assign bottom_output_enable_n = state.in_fix_en[3:2];
	assign top_output_enable_n = state.in_fix_en[1:0];
	assign flex_output_enable_n = state.flex_en;

	// Wake free-run PLL, zero for A up to three for D
	assign free_run_valid = state.free_valid;
	assign free_run_pll = state.wake_sel[POS_WAKE_HI:POS_WAKE_LO];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);

	// Selector zero in output mode gives low
	a_pin_zero_sel: assert property (
		(state.pin_config[POS_PIN_DIR] && state.pin_config[2:0] == SEL_ZERO)
		|=> (multipurpose_pin_15_oe && !multipurpose_pin_15_out))
		else $error("pin not low for selector zero");

	// Input mode never drives the pin
	a_pin_input_mode: assert property (
		!state.pin_config[POS_PIN_DIR]
		|=> (!multipurpose_pin_15_oe && !multipurpose_pin_15_out))
		else $error("pin driven in input mode");

	// All alarms combined
	a_all_alarm_or: assert property (
		(state.pin_config[POS_PIN_DIR] && state.pin_config[2:0] == SEL_ALL)
		|=> (multipurpose_pin_15_out ==
		($past(pll_alarm(state.ev_sync)) || $past(mon_alarm(state.ev_sync)))))
		else $error("pin does not show all alarms");

	// PLL alarms only
	a_pll_alarm_or: assert property (
		(state.pin_config[POS_PIN_DIR] && state.pin_config[2:0] == SEL_PLL)
		|=> (multipurpose_pin_15_out == $past(pll_alarm(state.ev_sync))))
		else $error("pin does not show PLL alarms");

	// Input monitor alarms only
	a_mon_alarm_or: assert property (
		(state.pin_config[POS_PIN_DIR] && state.pin_config[2:0] == SEL_MON)
		|=> (multipurpose_pin_15_out == $past(mon_alarm(state.ev_sync))))
		else $error("pin does not show monitor alarms");

	// Monitoring status follows the event three cycles late
	a_status_sel: assert property (
		(state.pin_config[POS_PIN_DIR] && state.pin_config[2:0] == SEL_STATUS)
		[*2] |=> (multipurpose_pin_15_out == $past(monitor_events.monitor, 3)))
		else $error("pin does not show monitoring status");

	// Rail hold follows a write the next cycle
	a_rail_hold: assert property (
		(reg_write && reg_addr == OFS_SPARE)
		|=> (rail_switch_allowed == !$past(reg_wdata[POS_RAIL_HOLD])))
		else $error("rail hold not taken");

	// No forcing without the mapping bit
	a_holdover_map: assert property (
		(!state.spare[POS_HO_MAP]) |=> (pll_force_holdover == 4'h0))
		else $error("holdover forced while unmapped");

	// Illegal fuse values leave the pointer as it was
	a_fuse_refuse: assert property (
		(reg_write && reg_addr == OFS_FUSE_PTR && !fuse_legal(reg_wdata))
		|=> ($stable(fuse_page_select) && !fuse_page_select[POS_RESV_PAGE]))
		else $error("illegal fuse pointer taken");

	// Supply choice follows its write
	a_io_supply: assert property (
		(reg_write && reg_addr == OFS_IO_SUPPLY)
		|=> (io_supply_from_input == $past(reg_wdata[POS_SUPPLY])))
		else $error("supply select not taken");

	// Enables follow their write
	a_enable_write: assert property (
		(reg_write && reg_addr == OFS_IN_FIX_EN)
		|=> ({clock_input_enable_n, bottom_output_enable_n, top_output_enable_n}
		== $past(reg_wdata)))
		else $error("enable write not taken");

	// Free run not flagged one cycle after the enable is clear
	a_free_run_gate: assert property (
		state.io_supply[POS_FREE_EN] == 1'b0 |=> !free_run_valid)
		else $error("free run active while disabled");

	// Free run flagged one cycle after the enable is set
	a_free_run_on: assert property (
		state.io_supply[POS_FREE_EN] |=> free_run_valid)
		else $error("free run not active while enabled");

	// Output mode always drives the pin
	a_pin_output_mode: assert property (
		state.pin_config[POS_PIN_DIR]
		|=> multipurpose_pin_15_oe)
		else $error("pin not driven in output mode");

	// Mapped holdover requests pass one cycle late
	a_holdover_pass: assert property (
		state.spare[POS_HO_MAP]
		|=> (pll_force_holdover == $past(holdover_force_req)))
		else $error("mapped holdover request not passed");

	// Legal fuse values are taken as written
	a_fuse_accept: assert property (
		(reg_write && reg_addr == OFS_FUSE_PTR && fuse_legal(reg_wdata))
		|=> (fuse_page_select == $past(reg_wdata)))
		else $error("legal fuse pointer not taken");

	// Bottom fixed output enables follow their write
	a_bottom_enable: assert property (
		(reg_write && reg_addr == OFS_IN_FIX_EN)
		|=> (bottom_output_enable_n == $past(reg_wdata[3:2])))
		else $error("bottom enable write not taken");

	// Top fixed output enables follow their write
	a_top_enable: assert property (
		(reg_write && reg_addr == OFS_IN_FIX_EN)
		|=> (top_output_enable_n == $past(reg_wdata[1:0])))
		else $error("top enable write not taken");

	// Flexible output enables follow their write
	a_flex_write: assert property (
		(reg_write && reg_addr == OFS_FLEX_EN)
		|=> (flex_output_enable_n == $past(reg_wdata)))
		else $error("flex enable write not taken");

	// Wake PLL choice follows its write
	a_wake_pll_write: assert property (
		(reg_write && reg_addr == OFS_WAKE_SEL)
		|=> (free_run_pll == $past(reg_wdata[POS_WAKE_HI:POS_WAKE_LO])))
		else $error("wake PLL select not taken");

endmodule : clock_generic_config_regs

// ===== core/pin_signal_mux.sv
// Selector that picks the internal signal shown on pin 15
`timescale 1ns/100ps
module pin_signal_mux
	import clock_cfg_pkg::*;
(
	input wire sense_t events,
	input wire logic [2:0] select,
	output logic selected
);

	// ----------------------------------------------------------------
	// Signal choice
	// ----------------------------------------------------------------
	// Pure decode; the caller registers the result
	always_comb begin
		unique case (select)
			SEL_ZERO: selected = 1'b0;
			SEL_ALL: selected = pll_alarm(events) | mon_alarm(events);
			SEL_PLL: selected = pll_alarm(events);
			SEL_MON: selected = mon_alarm(events);
			SEL_STATUS: selected = events.monitor;
			SEL_DBG0: selected = events.debug[0];
			SEL_DBG1: selected = events.debug[1];
			SEL_DBG2: selected = events.debug[2];
		endcase
	end

endmodule : pin_signal_mux

// ===== tb/cfg_host.sv
// Host model that drives the register port of the configuration page
`timescale 1ns/100ps
module cfg_host (
	input wire logic clock,
	output logic reg_write,
	output logic reg_read,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_ack
);
	// ----------------------------------------------------------------
	// Idle bus
	// ----------------------------------------------------------------
	// Nothing requested at time zero
	initial begin
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// ----------------------------------------------------------------
	// One access
	// ----------------------------------------------------------------
	// Request held until ack is seen; released lines show the inverse
	task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
		output logic [7:0] rdata, output logic lost);
		int n;
		lost = 1'b1;
		rdata = 8'h00;
		@(negedge clock);
		reg_write = wr;
		reg_read = !wr;
		reg_addr = addr;
		reg_wdata = wdata;
		// Bounded wait, so a missing ack cannot hang the run
		for (n = 0; n < 4 && lost; n++) begin
			@(negedge clock);
			if (reg_ack === 1'b1) begin
				lost = 1'b0;
				rdata = reg_rdata;
			end
		end
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = ~addr;
		reg_wdata = ~wdata;
	endtask : access
endmodule : cfg_host

// ===== tb/clock_generic_config_regs_test.sv
// Self-checking bench for the generic clock configuration page
`timescale 1ns/100ps
`define CHK(g, e) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end
module clock_generic_config_regs_test;
	import clock_cfg_pkg::*;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clock = 1'b0; // 250 MHz clock
	logic arst_n = 1'b0; // Reset held at start
	logic reg_write, reg_read, reg_ack; // Register port handshake
	logic [7:0] reg_addr, reg_wdata, reg_rdata; // Register port data
	sense_t ev = '0; // Detector events
	logic [3:0] hold_req = 4'h0; // Holdover requests
	logic pin_in = 1'b0; // Pin 15 input level
	logic pin_out, pin_oe, rail_ok, io_in, fr_valid; // Single-bit outputs
	logic [3:0] force_ho, in_en_n; // Holdover and input enables
	logic [1:0] bot_en_n, top_en_n, fr_pll; // Fixed enables, wake PLL
	logic [7:0] fuse_sel, flex_en_n; // Fuse pointer, flex enables
	int n_fail = 0; // Mismatches
	int total_checks = 0; // Comparisons
	int cycles = 0; // Timeout counter

	always #2 clock = ~clock;

	// ----------------------------------------------------------------
	// Design and host
	// ----------------------------------------------------------------
	clock_generic_config_regs dut_u (.clock(clock), .arst_n(arst_n), .reg_write(reg_write),
		.reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_ack(reg_ack), .monitor_events(ev),
		.holdover_force_req(hold_req), .multipurpose_pin_15_in(pin_in),
		.multipurpose_pin_15_out(pin_out), .multipurpose_pin_15_oe(pin_oe),
		.rail_switch_allowed(rail_ok), .io_supply_from_input(io_in),
		.pll_force_holdover(force_ho), .fuse_page_select(fuse_sel),
		.clock_input_enable_n(in_en_n), .bottom_output_enable_n(bot_en_n),
		.top_output_enable_n(top_en_n), .flex_output_enable_n(flex_en_n),
		.free_run_valid(fr_valid), .free_run_pll(fr_pll));
	cfg_host host_u (.clock(clock), .reg_write(reg_write), .reg_read(reg_read),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// Verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : test_done

	// Write, then let delayed outputs settle
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic [7:0] d;
		logic lost;
		host_u.access(1'b1, a, v, d, lost);
		`CHK(lost, 1'b0)
		repeat (3) @(negedge clock);
	endtask : wr

	// Read and compare
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic lost;
		host_u.access(1'b0, a, 8'h00, d, lost);
		`CHK(lost, 1'b0)
		`CHK(d, e)
	endtask : rd

	// Pin level expected for a selector code
	function automatic logic pin_exp(input logic [2:0] c, input sense_t s);
		case (c)
			3'h1: pin_exp = |{s.clock_loss, s.drift, s.loss_of_lock, s.freeze};
			3'h2: pin_exp = |{s.loss_of_lock, s.freeze};
			3'h3: pin_exp = |{s.clock_loss, s.drift};
			3'h4: pin_exp = s.monitor;
			3'h5: pin_exp = s.debug[0];
			3'h6: pin_exp = s.debug[1];
			3'h7: pin_exp = s.debug[2];
			default: pin_exp = 1'b0;
		endcase
	endfunction : pin_exp

	// Cycle ceiling
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] ofs [7];
		sense_t e;
		ofs = '{OFS_PIN_CONFIG, OFS_SPARE, OFS_FUSE_PTR, OFS_IO_SUPPLY, OFS_IN_FIX_EN,
			OFS_FLEX_EN, OFS_WAKE_SEL};
		repeat (8) @(negedge clock);
		arst_n = 1'b1;
		// Reset values
		`CHK({pin_oe, pin_out, in_en_n, bot_en_n, top_en_n, flex_en_n, fuse_sel}, 26'h0)
		for (int i = 0; i < 7; i++) begin
			rd(ofs[i], RST_REG);
		end
		$display("test reset done");
		// Active-low enables, both polarities of every bit
		for (int i = 0; i < 2; i++) begin
			wr(OFS_IN_FIX_EN, i ? 8'h59 : 8'hA6);
			`CHK({in_en_n, bot_en_n, top_en_n}, i ? 8'h59 : 8'hA6)
			wr(OFS_FLEX_EN, i ? 8'hA5 : 8'h5A);
			`CHK(flex_en_n, i ? 8'hA5 : 8'h5A)
			rd(OFS_FLEX_EN, i ? 8'hA5 : 8'h5A);
		end
		$display("test enables done");
		// Supply and wake-up free run
		wr(OFS_IO_SUPPLY, 8'h80);
		wr(OFS_WAKE_SEL, 8'hC0);
		`CHK({io_in, fr_valid, fr_pll}, 4'hB)
		wr(OFS_IO_SUPPLY, 8'h20);
		`CHK({io_in, fr_valid, fr_pll}, 4'h7)
		wr(OFS_WAKE_SEL, 8'h40);
		`CHK(fr_pll, 2'h1)
		rd(OFS_IO_SUPPLY, 8'h20);
		$display("test supply done");
		// Rail hold and holdover mapping
		hold_req = 4'hA;
		wr(OFS_SPARE, 8'h40);
		`CHK({rail_ok, force_ho}, 5'h1A)
		wr(OFS_SPARE, 8'h80);
		`CHK({rail_ok, force_ho}, 5'h00)
		hold_req = 4'h5;
		wr(OFS_SPARE, 8'hC0);
		`CHK({rail_ok, force_ho}, 5'h05)
		$display("test spare done");
		// Fuse pointer, reserved page and non-one-hot refused
		wr(OFS_FUSE_PTR, 8'h80);
		rd(OFS_FUSE_PTR, 8'h80);
		wr(OFS_FUSE_PTR, 8'h10);
		rd(OFS_FUSE_PTR, 8'h80);
		wr(OFS_FUSE_PTR, 8'h03);
		`CHK(fuse_sel, 8'h80)
		rd(OFS_STATUS, 8'h04);
		wr(OFS_FUSE_PTR, 8'h01);
		`CHK(fuse_sel, 8'h01)
		wr(8'h30, 8'hFF);
		rd(8'h30, 8'h00);
		$display("test fuse done");
		// Pin 15 selector over every code and event kind
		for (int p = 0; p < 6; p++) begin
			e = '0;
			case (p)
				0: e.clock_loss[2] = 1'b1;
				1: e.drift[0] = 1'b1;
				2: e.loss_of_lock[3] = 1'b1;
				3: e.freeze[1] = 1'b1;
				4: e.monitor = 1'b1;
				default: e.debug = 3'h5;
			endcase
			ev = e;
			for (int c = 0; c < 8; c++) begin
				wr(OFS_PIN_CONFIG, {5'h01, c[2:0]});
				repeat (3) @(negedge clock);
				`CHK(pin_oe, 1'b1)
				`CHK(pin_out, pin_exp(c[2:0], e))
			end
		end
		// Input mode leaves the pin undriven
		ev.clock_loss = 4'hF;
		pin_in = 1'b1;
		wr(OFS_PIN_CONFIG, 8'h01);
		repeat (3) @(negedge clock);
		`CHK({pin_oe, pin_out}, 2'b00)
		rd(OFS_STATUS, 8'h01);
		$display("test pin done");
		// Reset in mid-run clears every field again
		arst_n = 1'b0;
		repeat (2) @(negedge clock);
		`CHK({pin_oe, pin_out, in_en_n, bot_en_n, top_en_n, flex_en_n, fuse_sel}, 26'h0)
		`CHK({rail_ok, force_ho, io_in, fr_valid, fr_pll}, 9'h100)
		arst_n = 1'b1;
		for (int i = 0; i < 7; i++) begin
			rd(ofs[i], RST_REG);
		end
		$display("test mid reset done");
		test_done();
	end
endmodule : clock_generic_config_regs_test
